//--- hw/sgz_consts.vh
`ifndef SGZ_CONSTS_VH
`define SGZ_CONSTS_VH

// Register indexes on the control port
`define SGZ_ADDR_W             7
`define SGZ_ADDR_GAP_HIGH      7'h0F
`define SGZ_ADDR_GAP_LOW       7'h10
`define SGZ_ADDR_COPY_CTRL     7'h11
`define SGZ_ADDR_RATIO_HIGH    7'h12
`define SGZ_ADDR_RATIO_LOW     7'h13
`define SGZ_ADDR_WORD_C_HIGH   7'h14
`define SGZ_ADDR_WORD_C_LOW    7'h15
`define SGZ_ADDR_WORD_D_HIGH   7'h16
`define SGZ_ADDR_WORD_D_LOW    7'h17

// Reset values
`define SGZ_RST_GAP_HIGH       8'h00
`define SGZ_RST_GAP_LOW        8'h09
`define SGZ_RST_COPY_CTRL      8'h00
`define SGZ_RD_UNMAPPED        8'h00

// Copy control field positions
`define SGZ_CTRL_ADJUST_BIT    6
`define SGZ_CTRL_USER_BIT      5
`define SGZ_CTRL_STATUS_BIT    4
`define SGZ_CTRL_LIMIT_HI      3
`define SGZ_CTRL_LIMIT_LO      0
`define SGZ_CTRL_WR_MASK       8'h7F

// Unit gap limit ceiling
`define SGZ_LIMIT_MAX          4'h8

// Ratio field widths
`define SGZ_RATIO_W            15
`define SGZ_RATIO_HI_MSB       14
`define SGZ_RATIO_HI_LSB       8
`define SGZ_WORD_W             16

`endif

//--- hw/sgz_zero_run.v
`timescale 1ns/10ps
// Counts out a run of stuffed zeros, one per transmit slot
module sgz_zero_run #(
  parameter CNT_W = 16
) (
  input  wire             clk,
  input  wire             reset,
  input  wire             load,
  input  wire [CNT_W-1:0] load_count,
  input  wire             slot,
  output wire             busy
);
  reg [CNT_W-1:0] left_r;
  reg [CNT_W-1:0] left_nxt;

  assign busy = (left_r != {CNT_W{1'b0}});

  always @* begin
    left_nxt = left_r;
    // A new run restarts the count; an old tail is not added on
    if (load) begin
      left_nxt = load_count;
    end else if (slot && busy) begin
      left_nxt = left_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      left_r <= {CNT_W{1'b0}};
    end else begin
      left_r <= left_nxt;
    end
  end
endmodule // sgz_zero_run

//--- hw/sgz_regs.v
`timescale 1ns/10ps
`include "sgz_consts.vh"

module sgz_regs #(
  parameter GAP_W   = 16,
  parameter LIMIT_W = 4
) (
  input  wire                      clk,
  input  wire                      reset,
  input  wire [`SGZ_ADDR_W-1:0]    reg_addr,
  input  wire                      reg_wr_en,
  input  wire [7:0]                reg_wr_data,
  input  wire                      reg_rd_en,
  output wire [7:0]                reg_rd_data,
  input  wire                      rx_user_bit,
  input  wire                      rx_user_valid,
  output wire                      rx_user_ready,
  input  wire                      rx_status_bit,
  input  wire                      rx_status_valid,
  input  wire                      tx_slot,
  input  wire                      message_end,
  input  wire                      unit_end,
  output wire                      tx_user_bit,
  output wire                      tx_user_valid,
  output wire                      tx_status_bit,
  output wire                      tx_status_valid,
  output wire [GAP_W-1:0]          message_gap_count,
  input  wire [`SGZ_RATIO_W-1:0]   converter_rate_ratio,
  input  wire                      burst_detected,
  input  wire                      subframe_nonaudio,
  input  wire [`SGZ_WORD_W-1:0]    rx_word_c_a,
  input  wire [`SGZ_WORD_W-1:0]    rx_word_c_b,
  input  wire [`SGZ_WORD_W-1:0]    rx_word_d
);
  reg  [7:0]               gap_count_upper_r;
  reg  [7:0]               gap_count_lower_r;
  reg  [7:0]               copy_ctrl_r;
  reg  [`SGZ_RATIO_W-1:0]  ratio_r;
  reg  [`SGZ_WORD_W-1:0]   word_c_r;
  reg  [`SGZ_WORD_W-1:0]   word_d_r;
  reg  [`SGZ_WORD_W-1:0]   word_c_nxt;
  reg  [`SGZ_WORD_W-1:0]   word_d_nxt;
  reg  [7:0]               rd_data_r;
  reg  [7:0]               rd_data_nxt;
  reg                      tx_user_bit_r;
  reg                      tx_user_valid_r;
  reg                      tx_status_bit_r;
  reg                      tx_status_valid_r;
  reg  [LIMIT_W-1:0]       unit_zeros;
  wire                     unit_gap_adjust_enable;
  wire                     user_bit_copy_enable;
  wire                     status_bit_copy_enable;
  wire [LIMIT_W-1:0]       unit_gap_zero_limit;
  wire                     msg_busy;
  wire                     unit_busy;
  wire                     stuffing;

  assign unit_gap_adjust_enable = copy_ctrl_r[`SGZ_CTRL_ADJUST_BIT];
  assign user_bit_copy_enable   = copy_ctrl_r[`SGZ_CTRL_USER_BIT];
  assign status_bit_copy_enable = copy_ctrl_r[`SGZ_CTRL_STATUS_BIT];
  assign unit_gap_zero_limit    = copy_ctrl_r[`SGZ_CTRL_LIMIT_HI:`SGZ_CTRL_LIMIT_LO];
  assign message_gap_count      = {gap_count_upper_r, gap_count_lower_r};
  assign stuffing               = msg_busy | unit_busy;
  // Receiver is held off while zeros go out, so no user bit is lost
  assign rx_user_ready          = ~stuffing;
  assign reg_rd_data            = rd_data_r;
  assign tx_user_bit            = tx_user_bit_r;
  assign tx_user_valid          = tx_user_valid_r;
  assign tx_status_bit          = tx_status_bit_r;
  assign tx_status_valid        = tx_status_valid_r;

  // Codes above eight are clamped; the host should not use them
  always @* begin
    if (!unit_gap_adjust_enable) begin
      unit_zeros = {LIMIT_W{1'b0}};
    end else if (unit_gap_zero_limit > `SGZ_LIMIT_MAX) begin
      unit_zeros = `SGZ_LIMIT_MAX;
    end else begin
      unit_zeros = unit_gap_zero_limit;
    end
  end

  sgz_zero_run #(
    .CNT_W      (GAP_W)
  ) u_msg_gap (
    .clk        (clk),
    .reset      (reset),
    .load       (message_end),
    .load_count (message_gap_count),
    .slot       (tx_slot),
    .busy       (msg_busy)
  );

  sgz_zero_run #(
    .CNT_W      (LIMIT_W)
  ) u_unit_gap (
    .clk        (clk),
    .reset      (reset),
    .load       (unit_end & user_bit_copy_enable),
    .load_count (unit_zeros),
    .slot       (tx_slot),
    .busy       (unit_busy)
  );

  // Host register writes
  always @(posedge clk) begin
    if (reset) begin
      gap_count_upper_r <= `SGZ_RST_GAP_HIGH;
      gap_count_lower_r <= `SGZ_RST_GAP_LOW;
      copy_ctrl_r       <= `SGZ_RST_COPY_CTRL;
    end else if (reg_wr_en) begin
      case (reg_addr)
        `SGZ_ADDR_GAP_HIGH: begin
          gap_count_upper_r <= reg_wr_data;
        end
        `SGZ_ADDR_GAP_LOW: begin
          gap_count_lower_r <= reg_wr_data;
        end
        `SGZ_ADDR_COPY_CTRL: begin
          copy_ctrl_r <= reg_wr_data & `SGZ_CTRL_WR_MASK;
        end
        // Read-only and unmapped indexes ignore writes
        default: begin
          copy_ctrl_r <= copy_ctrl_r;
        end
      endcase
    end
  end

  // Burst words follow the receiver; zero when no burst is seen
  always @* begin
    word_c_nxt = {`SGZ_WORD_W{1'b0}};
    word_d_nxt = {`SGZ_WORD_W{1'b0}};
    if (burst_detected) begin
      word_c_nxt = rx_word_c_a;
      word_d_nxt = subframe_nonaudio ? rx_word_c_b : rx_word_d;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      ratio_r  <= {`SGZ_RATIO_W{1'b0}};
      word_c_r <= {`SGZ_WORD_W{1'b0}};
      word_d_r <= {`SGZ_WORD_W{1'b0}};
    end else begin
      ratio_r  <= converter_rate_ratio;
      word_c_r <= word_c_nxt;
      word_d_r <= word_d_nxt;
    end
  end

  // Read mux, registered so data stays stable for the port
  always @* begin
    case (reg_addr)
      `SGZ_ADDR_GAP_HIGH:   rd_data_nxt = gap_count_upper_r;
      `SGZ_ADDR_GAP_LOW:    rd_data_nxt = gap_count_lower_r;
      `SGZ_ADDR_COPY_CTRL:  rd_data_nxt = copy_ctrl_r;
      `SGZ_ADDR_RATIO_HIGH: rd_data_nxt = {1'b0,
                              ratio_r[`SGZ_RATIO_HI_MSB:`SGZ_RATIO_HI_LSB]};
      `SGZ_ADDR_RATIO_LOW:  rd_data_nxt = ratio_r[7:0];
      `SGZ_ADDR_WORD_C_HIGH: rd_data_nxt = word_c_r[15:8];
      `SGZ_ADDR_WORD_C_LOW: rd_data_nxt = word_c_r[7:0];
      `SGZ_ADDR_WORD_D_HIGH: rd_data_nxt = word_d_r[15:8];
      `SGZ_ADDR_WORD_D_LOW: rd_data_nxt = word_d_r[7:0];
      default:              rd_data_nxt = `SGZ_RD_UNMAPPED;
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      rd_data_r <= `SGZ_RD_UNMAPPED;
    end else if (reg_rd_en) begin
      rd_data_r <= rd_data_nxt;
    end
  end

  // User bit path: stuffed zeros take priority over copied bits
  always @(posedge clk) begin
    if (reset) begin
      tx_user_bit_r   <= 1'b0;
      tx_user_valid_r <= 1'b0;
    end else if (tx_slot && stuffing) begin
      tx_user_bit_r   <= 1'b0;
      tx_user_valid_r <= 1'b1;
    end else if (rx_user_valid && user_bit_copy_enable) begin
      tx_user_bit_r   <= rx_user_bit;
      tx_user_valid_r <= 1'b1;
    end else begin
      tx_user_valid_r <= 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      tx_status_bit_r   <= 1'b0;
      tx_status_valid_r <= 1'b0;
    end else begin
      tx_status_valid_r <= rx_status_valid & status_bit_copy_enable;
      if (rx_status_valid && status_bit_copy_enable) begin
        tx_status_bit_r <= rx_status_bit;
      end
    end
  end
endmodule // sgz_regs

//--- bench/sgz_regs_properties.sv
`timescale 1ns/10ps
module sgz_regs_chk #(parameter GAP_W = 16) (
  input wire             clk,
  input wire             reset,
  input wire [6:0]       reg_addr,
  input wire             reg_rd_en,
  input wire [7:0]       reg_rd_data,
  input wire             rx_user_valid,
  input wire             rx_status_bit,
  input wire             rx_status_valid,
  input wire             tx_slot,
  input wire             message_end,
  input wire             rx_user_ready,
  input wire             tx_user_valid,
  input wire             tx_status_bit,
  input wire             tx_status_valid,
  input wire [GAP_W-1:0] message_gap_count,
  input wire [14:0]      converter_rate_ratio,
  input wire             burst_detected,
  input wire             subframe_nonaudio,
  input wire [15:0]      rx_word_c_a,
  input wire [15:0]      rx_word_c_b,
  input wire [15:0]      rx_word_d
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  gap_reset_a:
    assert property ($fell(reset) |-> message_gap_count == 16'h0009) else $error("gap reset");
  run_stall_a:
    assert property (message_end && message_gap_count != 0 |=> !rx_user_ready) else $error("no run");
  user_source_a:
    assert property (tx_user_valid |-> $past(rx_user_valid || tx_slot)) else $error("user src");
  status_copy_a:
    assert property (tx_status_valid |-> $past(rx_status_valid)
      && tx_status_bit == $past(rx_status_bit)) else $error("status copy");
  ratio_high_a:
    assert property (reg_rd_en && reg_addr == 7'h12 |=> reg_rd_data ==
      {1'b0, $past(converter_rate_ratio[14:8], 2)}) else $error("ratio high");
  word_c_a:
    assert property (reg_rd_en && reg_addr == 7'h14 |=> reg_rd_data == ($past(burst_detected, 2)
      ? $past(rx_word_c_a[15:8], 2) : 8'h00)) else $error("word c");
  word_d_a:
    assert property (reg_rd_en && reg_addr == 7'h16 |=> reg_rd_data == (!$past(burst_detected, 2)
      ? 8'h00 : $past(subframe_nonaudio, 2) ? $past(rx_word_c_b[15:8], 2)
      : $past(rx_word_d[15:8], 2))) else $error("word d");
  unmapped_read_a:
    assert property (reg_rd_en && (reg_addr < 7'h0F || reg_addr > 7'h17) |=> reg_rd_data == 8'h00)
      else $error("unmapped");
endmodule // sgz_regs_chk

bind sgz_regs sgz_regs_chk #(.GAP_W(GAP_W)) chk_u (.clk, .reset, .reg_addr, .reg_rd_en,
  .reg_rd_data, .rx_user_valid, .rx_status_bit, .rx_status_valid, .tx_slot, .message_end,
  .rx_user_ready, .tx_user_valid, .tx_status_bit, .tx_status_valid, .message_gap_count,
  .converter_rate_ratio, .burst_detected, .subframe_nonaudio, .rx_word_c_a, .rx_word_c_b,
  .rx_word_d);

//--- bench/sgz_regs_tb.sv
`timescale 1ns/10ps
module sgz_regs_tb;
  reg         clk = 0, reset = 1, reg_wr_en = 0, reg_rd_en = 0, pend;
  reg         rx_user_bit = 0, rx_status_bit = 0, burst_detected = 0, subframe_nonaudio = 0;
  reg  [4:0]  pv = 0;
  reg  [6:0]  reg_addr = 0;
  reg  [7:0]  reg_wr_data = 0, qr[$];
  reg  [14:0] converter_rate_ratio = 0;
  reg  [15:0] rx_word_c_a = 0, rx_word_c_b = 0, rx_word_d = 0;
  reg  [31:0] seed = 32'h26C26EDF;
  reg         qu[$], qs[$];
  wire [7:0]  reg_rd_data;
  wire [15:0] message_gap_count;
  wire        rx_user_ready, tx_user_bit, tx_user_valid, tx_status_bit, tx_status_valid;
  wire        rx_user_valid, rx_status_valid, tx_slot, message_end, unit_end;
  integer     n_errors = 0, tests_run = 0, i, k;
  assign {rx_user_valid, rx_status_valid, tx_slot, message_end, unit_end} = pv;
  always #10 clk = ~clk;
  sgz_regs dut_u (.clk, .reset, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_en, .reg_rd_data,
    .rx_user_bit, .rx_user_valid, .rx_user_ready, .rx_status_bit, .rx_status_valid, .tx_slot,
    .message_end, .unit_end, .tx_user_bit, .tx_user_valid, .tx_status_bit, .tx_status_valid,
    .message_gap_count, .converter_rate_ratio, .burst_detected, .subframe_nonaudio,
    .rx_word_c_a, .rx_word_c_b, .rx_word_d);
  function [31:0] xs(input [31:0] s);
    xs = s ^ (s << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task step; begin @(posedge clk); #1; end endtask
  task chk8(input [7:0] g, input [7:0] e); begin
    tests_run = tests_run + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  end endtask
  task chk1(input g, input e); chk8({7'h00, g}, {7'h00, e}); endtask
  // Idle cycle after each access so no strobe is raised and lowered in one step
  task wr(input [6:0] a, input [7:0] d); begin
    reg_addr = a; reg_wr_data = d; reg_wr_en = 1; step; reg_wr_en = 0; step;
  end endtask
  task rd(input [6:0] a, input [7:0] e); begin
    qr.push_back(e); reg_addr = a; reg_rd_en = 1; step; reg_rd_en = 0; step;
  end endtask
  task pul(input [4:0] v); begin pv = v; step; pv = 5'h00; step; end endtask
  task conclude; begin
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  end endtask
  // Empty queue pops unknown, so any unrequested output is a mismatch
  always @(posedge clk) begin
    pend = reg_rd_en;
    #5;
    if (pend) chk8(reg_rd_data, qr.pop_front());
    if (tx_user_valid) chk1(tx_user_bit, qu.pop_front());
    if (tx_status_valid) chk1(tx_status_bit, qs.pop_front());
  end
  initial begin #200000; n_errors = n_errors + 1; conclude; end
  initial begin
    repeat (3) step;
    reset = 0;
    rd(7'h0F, 8'h00);
    rd(7'h10, 8'h09);
    chk8(message_gap_count[15:8], 8'h00);
    chk8(message_gap_count[7:0], 8'h09);
    rd(7'h18, 8'h00);
    seed = xs(seed);
    wr(7'h0F, seed[7:0]);
    wr(7'h10, seed[15:8]);
    wr(7'h16, 8'hFF);
    wr(7'h11, 8'hFF);
    rd(7'h0F, seed[7:0]);
    rd(7'h10, seed[15:8]);
    chk8(message_gap_count[15:8], seed[7:0]);
    chk8(message_gap_count[7:0], seed[15:8]);
    rd(7'h11, 8'h7F);
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      {rx_word_c_a, converter_rate_ratio} = seed[30:0];
      seed = xs(seed);
      {rx_word_c_b, rx_word_d} = seed;
      burst_detected = (i != 0);
      subframe_nonaudio = (i == 2);
      step;
      rd(7'h12, {1'b0, converter_rate_ratio[14:8]});
      rd(7'h13, converter_rate_ratio[7:0]);
      rd(7'h14, burst_detected ? rx_word_c_a[15:8] : 8'h00);
      rd(7'h15, burst_detected ? rx_word_c_a[7:0] : 8'h00);
      rd(7'h16, !burst_detected ? 8'h00 : subframe_nonaudio ? rx_word_c_b[15:8]
        : rx_word_d[15:8]);
      rd(7'h17, !burst_detected ? 8'h00 : subframe_nonaudio ? rx_word_c_b[7:0]
        : rx_word_d[7:0]);
    end
    wr(7'h11, 8'h30);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      {rx_user_bit, rx_status_bit} = seed[1:0];
      qu.push_back(seed[1]);
      qs.push_back(seed[0]);
      pul(5'h18);
    end
    wr(7'h11, 8'h00);
    pul(5'h18);
    wr(7'h0F, 8'h00);
    wr(7'h10, 8'h03);
    wr(7'h11, 8'h20);
    pul(5'h02);
    chk1(rx_user_ready, 1'b0);
    for (i = 0; i < 4; i = i + 1) begin
      if (i < 3) qu.push_back(1'b0);
      pul(5'h04);
    end
    chk1(rx_user_ready, 1'b1);
    for (i = 0; i < 10; i = i + 1) begin
      wr(7'h11, i == 9 ? 8'h22 : 8'h60 | i);
      pul(5'h01);
      for (k = 0; k <= i && k < 9; k = k + 1) begin
        if (k < i && i < 9) qu.push_back(1'b0);
        pul(5'h04);
      end
    end
    // Out-of-range limit code: the block clamps it to the ceiling of eight
    wr(7'h11, 8'h6F);
    pul(5'h01);
    for (k = 0; k < 9; k = k + 1) begin
      if (k < 8) qu.push_back(1'b0);
      pul(5'h04);
    end
    repeat (4) step;
    chk1(qr.size() + qu.size() + qs.size() != 0, 1'b0);
    conclude;
  end
endmodule // sgz_regs_tb
